// [hdl/ees_i2c_slave.sv]
// Purpose: Two-wire serial slave of a small byte memory with page writes.
// Assumes: SCL and SDA synchronous to clk_sys; SCL high and low last at least 4 clocks.
// Notes:   Registered open-drain output; page buffer committed after STOP.
// Functional notes
// - Sample on SCL rise, change after fall
// - Data line only pulled low or released
// - Undriven select pins read as low
// - Zero pulls low, one releases line
// - SDA change during SCL high is condition
// - START is SDA fall, SCL high
// - STOP launches write or ends read
// - Upper four address bits must match type
// - Three bits: pin compare or high address
// - Last address bit selects read or write
// - Acknowledge address, byte address, write data
// - Read bytes until master withholds acknowledge
// - Byte write: address, byte address, data, STOP
// - Busy write: line released, no response
// - Buffer sixteen bytes, commit after STOP
// - Write data bumps only low four bits
// - Overflow wraps within page, overwriting
// - Read without byte address uses pointer
// - Busy: no acknowledge to slave address
// - Sequential read wraps at memory end
`timescale 1ns/10ps
`default_nettype none
module ees_i2c_slave
   import ees_pkg::*;
#(
   parameter int unsigned ADDR_W      = ADDR_W_DEF,  // Memory address width
   parameter int unsigned WR_BUSY_CNT = WR_BUSY_CYC  // Busy length in clocks
) (
   input  wire logic          clk_sys,
   input  wire logic          arst_n,
   input  wire logic          scl_i,                  // Serial clock level
   input  wire logic          sda_i,                  // Serial data level on the wire
   output logic               sda_o,                  // Always low when enabled
   output logic               sda_oe,                 // High while pulling low
   input  wire logic [2:0]    device_select_pins,     // Select pin levels
   input  wire logic [2:0]    device_select_driven,   // High where a pin is driven
   output logic               internal_write_busy     // Write cycle in progress
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int unsigned BCNT_W = $clog2(WR_BUSY_CNT + 1);
   localparam int unsigned HI_W   = ADDR_W - PAGE_W;
   if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MIN + SEL_BITS) begin : g_bad_addr
      $error("ADDR_W must be 8 to 11");
   end
   if (WR_BUSY_CNT <= PAGE_BYTES) begin : g_bad_busy
      $error("WR_BUSY_CNT must exceed the page depth");
   end

   localparam logic [BCNT_W-1:0] BCNT_LOAD = BCNT_W'(WR_BUSY_CNT - 1);
   localparam logic [4:0]        CIDX_END  = 5'(PAGE_BYTES);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ees_state_t        state_q, state_d;        // Bit-level sequencer
   ees_role_t         role_q,  role_d;         // Meaning of the byte in flight
   logic              rd_q,    rd_d;           // Direction of this session
   logic [3:0]        cnt_q,   cnt_d;          // SCL rises within a byte
   logic [7:0]        sh_q,    sh_d;           // Shift register
   logic [ADDR_W-1:0] ptr_q,   ptr_d;          // Address pointer
   logic [7:0]        buf_q [PAGE_BYTES];      // Page buffer
   logic [7:0]        buf_d [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] vld_q, vld_d;        // Buffered entries
   logic              oe_q,    oe_d;           // Registered pull-down
   logic              busy_q,  busy_d;         // Internal write cycle
   logic [BCNT_W-1:0] bcnt_q,  bcnt_d;         // Busy countdown
   logic              cmt_q,   cmt_d;          // Committing buffer
   logic [4:0]        cidx_q,  cidx_d;         // Commit entry index
   logic [HI_W-1:0]   page_q,  page_d;         // Page being committed
   logic              scl_q,   sda_q;          // Previous pin levels

   // ----------------------------------------------------------------
   // Bus events
   // ----------------------------------------------------------------
   logic scl_rise;                             // Sampling moment
   logic scl_fall;                             // Output change moment
   logic start_ev;                             // SDA falls, SCL high
   logic stop_ev;                              // SDA rises, SCL high

   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   assign start_ev = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_ev  = scl_i & scl_q & ~sda_q & sda_i;

   // ----------------------------------------------------------------
   // Slave address match
   // ----------------------------------------------------------------
   logic [2:0] sel_eff;                        // Pin levels after pull-down
   logic [2:0] sel_ok;                         // Per-bit match
   logic       addr_match;                     // Whole address accepted

   assign sel_eff = device_select_pins & device_select_driven;

   // Low-density parts compare pins, higher ones take address bits
   for (genvar i = 0; i < SEL_BITS; i++) begin : g_sel
      if (i < ADDR_W - ADDR_W_MIN) begin : g_hi
         assign sel_ok[i] = 1'b1;
      end else begin : g_pin
         assign sel_ok[i] = (sh_q[i+1] == sel_eff[i]);
      end
   end

   assign addr_match = (sh_q[7:4] == DEV_TYPE) & (&sel_ok);

   // ----------------------------------------------------------------
   // Memory
   // ----------------------------------------------------------------
   logic              mem_we;                  // Commit write strobe
   logic [ADDR_W-1:0] mem_addr;                // Commit or read address
   logic [7:0]        mem_rdata;               // Byte at pointer, one clock late

   // Commit owns the port for the first 16 busy clocks; no reads happen then
   assign mem_we   = cmt_q & vld_q[cidx_q[3:0]];
   assign mem_addr = cmt_q ? {page_q, cidx_q[3:0]} : ptr_q;

   ees_mem #(
      .ADDR_W (ADDR_W)
   ) u_mem (
      .clk_sys (clk_sys),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (buf_q[cidx_q[3:0]]),
      .rdata   (mem_rdata)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      role_d  = role_q;
      rd_d    = rd_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      buf_d   = buf_q;
      vld_d   = vld_q;
      oe_d    = oe_q;
      busy_d  = busy_q;
      bcnt_d  = bcnt_q;
      cmt_d   = cmt_q;
      cidx_d  = cidx_q;
      page_d  = page_q;

      // Busy interval from STOP, independent of bus traffic
      if (busy_q) begin
         if (bcnt_q == '0) begin
            busy_d = 1'b0;
         end else begin
            bcnt_d = bcnt_q - 1'b1;
         end
      end

      // Commit one buffered entry per clock, then drop the buffer
      if (cmt_q) begin
         if (cidx_q == CIDX_END - 5'h01) begin
            cmt_d = 1'b0;
            vld_d = '0;
         end
         cidx_d = cidx_q + 5'h01;
      end

      if (start_ev) begin
         // START restarts the byte engine from any state
         state_d = ST_RX;
         role_d  = RL_SLAVE;
         cnt_d   = CNT_RST;
         oe_d    = 1'b0;
      end else if (stop_ev) begin
         // STOP after buffered write data launches the write cycle
         state_d = ST_IDLE;
         oe_d    = 1'b0;
         if (!busy_q && !rd_q && (vld_q != '0)) begin
            busy_d = 1'b1;
            bcnt_d = BCNT_LOAD;
            cmt_d  = 1'b1;
            cidx_d = 5'h00;
            page_d = ptr_q[ADDR_W-1:PAGE_W];
         end
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // Nothing until START
               oe_d = 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], sda_i};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'(BYTE_BITS)) begin
                  unique case (role_q)
                     RL_SLAVE: begin
                        if (addr_match && !busy_q) begin
                           rd_d    = sh_q[0];
                           role_d  = RL_WORD;
                           state_d = ST_RX_ACK;
                           oe_d    = 1'b1;
                           // Write session takes its high address bits here
                           if (!sh_q[0]) begin
                              for (int b = ADDR_W_MIN; b < ADDR_W; b++) begin
                                 ptr_d[b] = sh_q[b-7];
                              end
                           end
                        end else begin
                           // Busy or foreign address: stay silent
                           state_d = ST_IDLE;
                        end
                     end
                     RL_WORD: begin
                        ptr_d[7:0] = sh_q;
                        vld_d      = '0;
                        role_d     = RL_DATA;
                        state_d    = ST_RX_ACK;
                        oe_d       = 1'b1;
                     end
                     RL_DATA: begin
                        // Later bytes of an overlong page overwrite earlier ones
                        buf_d[ptr_q[3:0]] = sh_q;
                        vld_d[ptr_q[3:0]] = 1'b1;
                        ptr_d[3:0]        = ptr_q[3:0] + 4'h1;
                        state_d           = ST_RX_ACK;
                        oe_d              = 1'b1;
                     end
                     default: begin
                        state_d = ST_IDLE;
                     end
                  endcase
               end
            end
            ST_RX_ACK: begin
               // Acknowledge held from one fall to the next
               if (scl_fall) begin
                  cnt_d = CNT_RST;
                  if (rd_q) begin
                     sh_d    = mem_rdata;
                     oe_d    = ~mem_rdata[7];
                     state_d = ST_TX;
                  end else begin
                     oe_d    = 1'b0;
                     state_d = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == 4'(BYTE_BITS)) begin
                     oe_d    = 1'b0;
                     state_d = ST_TX_ACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  ptr_d = ptr_q + 1'b1;
                  if (sda_i) begin
                     // Master withheld acknowledge: session over
                     state_d = ST_IDLE;
                  end
               end else if (scl_fall) begin
                  // Pointer moved at the rise, read data settled since
                  sh_d    = mem_rdata;
                  oe_d    = ~mem_rdata[7];
                  cnt_d   = CNT_RST;
                  state_d = ST_TX;
               end
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         role_q  <= RL_SLAVE;
         rd_q    <= 1'b0;
         cnt_q   <= CNT_RST;
         sh_q    <= SHIFT_RST;
         ptr_q   <= '0;
         for (int e = 0; e < PAGE_BYTES; e++) begin
            buf_q[e] <= SHIFT_RST;
         end
         vld_q   <= '0;
         oe_q    <= 1'b0;
         busy_q  <= 1'b0;
         bcnt_q  <= '0;
         cmt_q   <= 1'b0;
         cidx_q  <= 5'h00;
         page_q  <= '0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         role_q  <= role_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         buf_q   <= buf_d;
         vld_q   <= vld_d;
         oe_q    <= oe_d;
         busy_q  <= busy_d;
         bcnt_q  <= bcnt_d;
         cmt_q   <= cmt_d;
         cidx_q  <= cidx_d;
         page_q  <= page_d;
         scl_q   <= scl_i;
         sda_q   <= sda_i;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open drain: the only level ever driven is low
   assign sda_o               = 1'b0;
   assign sda_oe              = oe_q;
   assign internal_write_busy = busy_q;

endmodule
`default_nettype wire

// [hdl/ees_mem.sv]
// Purpose: Byte array of the memory, one port, registered read data.
// Assumes: Write and read never wanted in the same cycle.
// Notes:   No reset on the array; contents are undefined until written.
`timescale 1ns/10ps
`default_nettype none
module ees_mem
   import ees_pkg::*;
#(
   parameter int unsigned ADDR_W = ADDR_W_DEF
) (
   input  wire logic              clk_sys,
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mem_q [2**ADDR_W];   // Array of bytes

   // Write when asked; read into the output register every clock
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem_q[addr] <= wdata;
      end
      rdata <= mem_q[addr];
   end

endmodule
`default_nettype wire

// [hdl/ees_pkg.sv]
// Purpose: Shared constants and types of the two-wire memory slave.
// Assumes: System clock of 20 MHz; serial pins sampled on that clock.
// Notes:   Shared offsets, counts and the shift and bit-counter reset values live here.
`default_nettype none
package ees_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS            = 50;        // 20 MHz system clock
   localparam int unsigned INTERNAL_WRITE_BUSY_TIME_NS = 5000000; // Internal write busy time, 5 ms
   // Busy is a least time, so round up to whole cycles
   localparam int unsigned WR_BUSY_CYC =
      (INTERNAL_WRITE_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Addressing
   // ----------------------------------------------------------------
   localparam logic [3:0] DEV_TYPE      = 4'hA;  // Fixed device-type pattern
   localparam int unsigned PAGE_BYTES   = 16;    // Page buffer depth
   localparam int unsigned PAGE_W       = 4;     // Page-local address bits
   localparam int unsigned SEL_BITS     = 3;     // Select / high-address bits
   localparam int unsigned BYTE_BITS    = 8;     // Bits per byte before the ack
   localparam int unsigned ADDR_W_DEF   = 11;    // Largest density by default
   localparam int unsigned ADDR_W_MIN   = 8;     // Smallest density

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SHIFT_RST     = 8'h00;
   localparam logic [3:0] CNT_RST       = 4'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,   // Ignoring bus until START
      ST_RX     = 3'b001,   // Shifting a byte in
      ST_RX_ACK = 3'b010,   // Driving our acknowledge
      ST_TX     = 3'b011,   // Shifting a byte out
      ST_TX_ACK = 3'b100    // Sampling the master acknowledge
   } ees_state_t;

   typedef enum logic [1:0] {
      RL_SLAVE  = 2'b00,    // Next byte is the slave address
      RL_WORD   = 2'b01,    // Next byte is the byte address
      RL_DATA   = 2'b10     // Next bytes are write data
   } ees_role_t;

endpackage
`default_nettype wire

// [tb/ees_i2c_slave_sva.sv]
// Purpose: Port-level checks on the two-wire memory slave.
// Assumes: Master holds SCL low and high for at least 5 clocks each.
// Notes:   Bound into every instance of the slave.
`timescale 1ns/10ps
`default_nettype none
module ees_i2c_slave_sva
   import ees_pkg::*;
#(
   parameter int unsigned ADDR_W      = ADDR_W_DEF,
   parameter int unsigned WR_BUSY_CNT = WR_BUSY_CYC
) (
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [2:0] device_select_pins,
   input wire logic [2:0] device_select_driven,
   input wire logic       internal_write_busy
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic [31:0] cnt_q, cnt_d;   // Busy clocks so far
   logic        woke_q, woke_d; // START seen since reset
   logic        scl_q, sda_q;   // Pin levels one clock ago

   // Next values; a START is only ever latched, never forgotten
   always_comb begin
      cnt_d  = internal_write_busy ? cnt_q + 32'h1 : 32'h0;
      woke_d = woke_q | (scl_i & scl_q & sda_q & ~sda_i);
   end

   // Registers only
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q  <= 32'h0;
         woke_q <= 1'b0;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         cnt_q  <= cnt_d;
         woke_q <= woke_d;
         scl_q  <= scl_i;
         sda_q  <= sda_i;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // STOP seen on the pins at the previous edge
   sequence stop_seq;
      $past(scl_i, 2) && $past(scl_i) && !$past(sda_i, 2) && $past(sda_i);
   endsequence
   // A driven bit lasts the rest of SCL low and all of SCL high
   sequence hold_seq;
      sda_oe [*8];
   endsequence

   low_only_a: assert property (sda_oe |-> sda_o == 1'b0)
      else $error("data pin driven high");
   // Output register moves at the edge that first sees SCL low, seen here one clock later
   fall_timing_a: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i) && $past(scl_i, 2))
      else $error("data output moved away from clock fall");
   high_stable_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data output moved with clock high");
   ack_hold_a: assert property ($rose(sda_oe) |=> hold_seq)
      else $error("driven bit too short");
   busy_quiet_a: assert property (internal_write_busy |-> !sda_oe)
      else $error("data pin driven while busy");
   busy_len_a: assert property ($fell(internal_write_busy) |-> cnt_q == WR_BUSY_CNT)
      else $error("busy length wrong");
   busy_cause_a: assert property ($rose(internal_write_busy) |-> stop_seq)
      else $error("busy without STOP");
   wake_start_a: assert property ($rose(sda_oe) |-> woke_q)
      else $error("answer before any START");
endmodule
bind ees_i2c_slave ees_i2c_slave_sva #(.ADDR_W(ADDR_W), .WR_BUSY_CNT(WR_BUSY_CNT)) u_sva (
   .clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .device_select_pins(device_select_pins),
   .device_select_driven(device_select_driven), .internal_write_busy(internal_write_busy));
`default_nettype wire

// [tb/ees_master.sv]
// Purpose: Behavioural two-wire bus master facing the slave.
// Assumes: Tasks are called from the bench one at a time.
// Notes:   SCL stands high between frames; 5 clocks per phase.
`timescale 1ns/10ps
`default_nettype none
module ees_master (
   input  wire logic clk_sys,
   input  wire logic sda,      // Resolved wire level
   output logic      scl,      // Serial clock, ours alone
   output logic      sda_low   // High while we pull data low
);
   // Idle bus: both lines released
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One bit; data moves only with SCL low, sampled late in the high phase
   task automatic bit_cycle(input logic low_en, output logic seen);
      scl <= 1'b0;
      tick(2);
      sda_low <= low_en;
      tick(3);
      scl <= 1'b1;
      tick(5);
      seen = sda;
   endtask

   // START, also repeated; only called on an idle bus or our own session
   task automatic start();
      scl <= 1'b0;
      tick(2);
      sda_low <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(5);
      sda_low <= 1'b1;
      tick(5);
   endtask

   task automatic stop();
      scl <= 1'b0;
      tick(2);
      sda_low <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(5);
      sda_low <= 1'b0;
      tick(5);
   endtask

   // Byte out MSB first, then release and read the answer
   task automatic send_byte(input logic [7:0] b, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(~b[i], s);
      end
      bit_cycle(1'b0, nack);
   endtask

   // Byte in; a withheld acknowledge ends the read
   task automatic recv_byte(input logic nack_out, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b0, s);
         b[i] = s;
      end
      bit_cycle(~nack_out, s);
   endtask
endmodule
`default_nettype wire

// [tb/i2c_eeprom_slave_interface_test.sv]
// Purpose: Self-checking bench of the two-wire memory slave.
// Assumes: 9-bit memory: slave bit 1 is an address bit, bits 3:2 match pins.
// Notes:   Busy shortened to 400 clocks so polls finish inside it.
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_slave_interface_test;
   import ees_pkg::*;
   localparam int unsigned AW   = 9;
   localparam int unsigned BUSY = 400;

   logic       clk_sys, arst_n;         // Clock and reset
   logic [2:0] sel_pins, sel_drv;       // Select pins, driven mask
   logic       scl, m_low, sda;         // Bus lines
   logic       sda_o, sda_oe, busy;     // Slave outputs
   logic [7:0] mem_m [int];             // Reference memory
   int         ptr_m;                   // Reference pointer
   int         bad_count, num_checks;   // Tallies
   int unsigned seed = 67;              // Random state

   // Wired-AND with pull-up
   assign sda = ~(m_low | (sda_oe & ~sda_o));

   ees_i2c_slave #(.ADDR_W(AW), .WR_BUSY_CNT(BUSY)) u_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .device_select_pins(sel_pins), .device_select_driven(sel_drv),
      .internal_write_busy(busy));
   ees_master u_mst (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(m_low));

   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Write n random bytes at a; n of 0 leaves a dummy write open
   task automatic wr(input logic [8:0] a, input int n);
      logic nk;
      logic [7:0] d;
      u_mst.start();
      u_mst.send_byte({DEV_TYPE, 2'b01, a[8], 1'b0}, nk);
      check({7'h00, nk}, 8'h00);
      u_mst.send_byte(a[7:0], nk);
      check({7'h00, nk}, 8'h00);
      ptr_m = int'(a);
      for (int k = 0; k < n; k++) begin
         d = 8'(xs());
         u_mst.send_byte(d, nk);
         check({7'h00, nk}, 8'h00);
         mem_m[(int'(a) & 'h1F0) | ((int'(a) + k) & 'hF)] = d;
      end
      if (n > 0) begin
         u_mst.stop();
         check({7'h00, busy}, 8'h01);
         // Poll while the cycle runs: no answer
         u_mst.start();
         u_mst.send_byte({DEV_TYPE, 4'h4}, nk);
         check({7'h00, nk}, 8'h01);
         u_mst.stop();
         for (int i = 0; i < 1000 && busy; i++) begin
            u_mst.tick(1);
         end
         check({7'h00, busy}, 8'h00);
      end
   endtask

   // Read n bytes from the pointer, withholding the last acknowledge
   task automatic rd(input int n);
      logic nk;
      logic [7:0] d;
      u_mst.start();
      u_mst.send_byte({DEV_TYPE, 4'h5}, nk);
      check({7'h00, nk}, 8'h00);
      for (int k = 0; k < n; k++) begin
         u_mst.recv_byte(k == n - 1, d);
         check(d, mem_m[ptr_m]);
         ptr_m = (ptr_m + 1) % (1 << AW);
      end
      u_mst.stop();
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog, main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Whole run needs under 10000 clocks
   initial begin
      #(30000 * 50);
      bad_count++;
      results();
   end

   initial begin
      logic nk;
      arst_n   = 1'b0;
      sel_pins = 3'b111;
      sel_drv  = 3'b011; // Top pin floats, so it must read low
      bad_count  = 0;
      num_checks = 0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      u_mst.tick(2);
      check({6'h00, sda_oe, busy}, 8'h00);
      // Byte with no START before it is ignored
      u_mst.send_byte({DEV_TYPE, 4'h4}, nk);
      check({7'h00, nk}, 8'h01);
      // Floating pin taken high, then wrong type
      u_mst.start();
      u_mst.send_byte({DEV_TYPE, 4'hC}, nk);
      check({7'h00, nk}, 8'h01);
      u_mst.send_byte({DEV_TYPE, 4'h4}, nk);
      check({7'h00, nk}, 8'h01);
      u_mst.start();
      u_mst.send_byte(8'hB4, nk);
      check({7'h00, nk}, 8'h01);
      u_mst.stop();
      // Page overflow, byte writes, wrap across memory end
      wr(9'h1F3, 18);
      wr(9'h000, 1);
      wr(9'h001, 1);
      wr(9'h1FE, 0);
      rd(3);
      rd(1);
      // Read back the page entries that the overflow overwrote
      wr(9'h1F3, 0);
      rd(2);
      results();
   end
endmodule
`default_nettype wire
